/* design/interrupt_status_flags.sv */
// Interrupt status word with enable mask, pending summary and level interrupt output
`default_nettype none
module interrupt_status_flags #(
    parameter int TimerW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [isf_pkg::ISF_ADDR_W-1:0] regAddr,
    input wire logic [isf_pkg::ISF_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [isf_pkg::ISF_DATA_W-1:0] regRdata,
    // Event sources
    input wire logic transceiverAEvent,
    input wire logic transceiverBEvent,
    input wire logic fieldbusEvent,
    input wire logic [TimerW-1:0] timerCountValue,
    input wire logic wakeDetect,
    input wire logic wakeControlPending,
    // De-assertion interval from the interrupt pin logic
    input wire logic deassertActive,
    // Interrupt outputs
    output logic pendingIrq,
    output logic irqOut
);
    import isf_pkg::*;

    logic [31:0] flag_r;
    logic [31:0] mask_r;
    logic [31:0] flagView;
    logic [7:0] readyCnt_r;
    logic readyDone_r;
    logic timerWrap;
    logic flagWr;
    logic maskWr;
    logic [31:0] unmasked;

    initial begin
        if (TimerW != 16) begin
            $error("TimerW must be 16 to match the wrap value");
        end
        if (ISF_READY_CYC > 255) begin
            $error("Ready delay too long for counter");
        end
    end

    assign flagWr = regWr && (regAddr == ISF_FLAG_OFS);
    assign maskWr = regWr && (regAddr == ISF_MASK_OFS);

    isf_wrap_detect #(
        .CountW(TimerW)
    ) uWrap (
        .clk(clk),
        .resetn(resetn),
        .count(timerCountValue),
        .wrapPulse(timerWrap)
    );

    // Mask word; reserved bits never store
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_r <= ISF_MASK_RST;
        end else if (maskWr) begin
            mask_r <= regWdata & ISF_IMPL_MASK;
        end
    end

    // Ready becomes valid a short fixed time after reset release
    always_ff @(posedge clk) begin
        if (!resetn) begin
            readyCnt_r <= 8'h00;
            readyDone_r <= 1'b0;
        end else if (!readyDone_r) begin
            if (readyCnt_r == 8'(ISF_READY_CYC - 1)) begin
                readyDone_r <= 1'b1;
            end else begin
                readyCnt_r <= readyCnt_r + 8'h01;
            end
        end
    end

    // Sticky flags: set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_r <= ISF_FLAG_RST;
        end else begin
            if (mask_r[ISF_BIT_SW]) begin
                flag_r[ISF_BIT_SW] <= 1'b1;
            end else if (flagWr && regWdata[ISF_BIT_SW]) begin
                flag_r[ISF_BIT_SW] <= 1'b0;
            end
            if (readyCnt_r == 8'(ISF_READY_CYC - 1) && !readyDone_r) begin
                flag_r[ISF_BIT_READY] <= 1'b1;
            end else if (flagWr && regWdata[ISF_BIT_READY]) begin
                flag_r[ISF_BIT_READY] <= 1'b0;
            end
            if (timerWrap) begin
                flag_r[ISF_BIT_TIMER] <= 1'b1;
            end else if (flagWr && regWdata[ISF_BIT_TIMER]) begin
                flag_r[ISF_BIT_TIMER] <= 1'b0;
            end
            if (wakeDetect) begin
                flag_r[ISF_BIT_WAKE] <= 1'b1;
            end else if (flagWr && regWdata[ISF_BIT_WAKE] && !wakeControlPending) begin
                flag_r[ISF_BIT_WAKE] <= 1'b0;
            end
        end
    end

    // Summary bits are live views of their sources, never stored
    always_comb begin
        flagView = flag_r & ISF_W1C_MASK;
        flagView[ISF_BIT_XCVR_B] = transceiverBEvent;
        flagView[ISF_BIT_XCVR_A] = transceiverAEvent;
        flagView[ISF_BIT_FIELDBUS] = fieldbusEvent;
    end

    assign unmasked = flagView & mask_r;
    assign pendingIrq = |unmasked;

    // Wake bypasses the de-assertion hold-off; the rest wait it out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= unmasked[ISF_BIT_WAKE] || (pendingIrq && !deassertActive);
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                ISF_FLAG_OFS: regRdata <= flagView;
                ISF_MASK_OFS: regRdata <= mask_r;
                ISF_PEND_OFS: regRdata <= {31'h00000000, pendingIrq};
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    property p_sw_set;
        @(posedge clk) disable iff (!resetn)
        mask_r[ISF_BIT_SW] |=> flag_r[ISF_BIT_SW];
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software flag not set");

    property p_sw_clr;
        @(posedge clk) disable iff (!resetn)
        (flagWr && regWdata[ISF_BIT_SW] && !mask_r[ISF_BIT_SW]) |=> !flag_r[ISF_BIT_SW];
    endproperty
    a_sw_clr: assert property (p_sw_clr) else $error("software flag not cleared");

    property p_zero_keeps;
        @(posedge clk) disable iff (!resetn)
        (flagWr && !regWdata[ISF_BIT_TIMER] && flag_r[ISF_BIT_TIMER]) |=> flag_r[ISF_BIT_TIMER];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

    // Edges since reset release, saturating; only the ready checks read it
    logic [7:0] sinceRelease_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sinceRelease_r <= 8'h00;
        end else if (sinceRelease_r != 8'hFF) begin
            sinceRelease_r <= sinceRelease_r + 8'h01;
        end
    end

    property p_ready_early;
        @(posedge clk) disable iff (!resetn)
        (sinceRelease_r < 8'(ISF_READY_CYC)) |-> !flag_r[ISF_BIT_READY];
    endproperty
    a_ready_early: assert property (p_ready_early) else $error("ready flag early");

    property p_ready;
        @(posedge clk) disable iff (!resetn)
        (sinceRelease_r == 8'(ISF_READY_CYC)) |-> flag_r[ISF_BIT_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("ready flag late");

    property p_ready_once;
        @(posedge clk) disable iff (!resetn)
        (sinceRelease_r > 8'(ISF_READY_CYC) && !flag_r[ISF_BIT_READY])
            |=> !flag_r[ISF_BIT_READY];
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready flag set twice");

    property p_ready_clr;
        @(posedge clk) disable iff (!resetn)
        (flagWr && regWdata[ISF_BIT_READY] && sinceRelease_r >= 8'(ISF_READY_CYC))
            |=> !flag_r[ISF_BIT_READY];
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");

    property p_timer;
        @(posedge clk) disable iff (!resetn)
        ($past(timerCountValue) == '0 && timerCountValue == '1 && $past(resetn))
            |=> flag_r[ISF_BIT_TIMER];
    endproperty
    a_timer: assert property (p_timer) else $error("timer wrap missed");

    property p_wake_hold;
        @(posedge clk) disable iff (!resetn)
        (flag_r[ISF_BIT_WAKE] && wakeControlPending) |=> flag_r[ISF_BIT_WAKE];
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake flag cleared early");

    property p_wake_irq;
        @(posedge clk) disable iff (!resetn)
        (unmasked[ISF_BIT_WAKE] && deassertActive) |=> irqOut;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("wake irq held off");

    property p_pending;
        @(posedge clk) disable iff (!resetn)
        pendingIrq == ((flagView & mask_r) != 32'h00000000);
    endproperty
    a_pending: assert property (p_pending) else $error("pending mismatch");

    property p_summary;
        @(posedge clk) disable iff (!resetn)
        (regRd && regAddr == ISF_FLAG_OFS) |=> regRdata[ISF_BIT_XCVR_A] == $past(transceiverAEvent);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_reserved;
        @(posedge clk) disable iff (!resetn)
        (regRdata & ~ISF_IMPL_MASK) == 32'h00000000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_timer_clr;
        @(posedge clk) disable iff (!resetn)
        (flagWr && regWdata[ISF_BIT_TIMER]
            && !($past(timerCountValue) == '0 && timerCountValue == '1))
            |=> !flag_r[ISF_BIT_TIMER];
    endproperty
    a_timer_clr: assert property (p_timer_clr) else $error("timer not cleared");

    property p_wake_set;
        @(posedge clk) disable iff (!resetn)
        wakeDetect |=> flag_r[ISF_BIT_WAKE];
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

    property p_wake_clr;
        @(posedge clk) disable iff (!resetn)
        (flagWr && regWdata[ISF_BIT_WAKE] && !wakeControlPending && !wakeDetect)
            |=> !flag_r[ISF_BIT_WAKE];
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake flag not cleared");

    property p_sw_keep;
        @(posedge clk) disable iff (!resetn)
        (flagWr && regWdata[ISF_BIT_SW] && mask_r[ISF_BIT_SW]) |=> flag_r[ISF_BIT_SW];
    endproperty
    a_sw_keep: assert property (p_sw_keep) else $error("armed software flag lost");

    sequence s_flag_read;
        regRd && regAddr == ISF_FLAG_OFS;
    endsequence

    property p_flag_read;
        @(posedge clk) disable iff (!resetn)
        s_flag_read |=> (regRdata & ISF_W1C_MASK) == ($past(flag_r) & ISF_W1C_MASK);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

    property p_summary_b;
        @(posedge clk) disable iff (!resetn)
        s_flag_read |=> regRdata[ISF_BIT_XCVR_B] == $past(transceiverBEvent);
    endproperty
    a_summary_b: assert property (p_summary_b) else $error("summary bit B wrong");

    property p_fieldbus;
        @(posedge clk) disable iff (!resetn)
        s_flag_read |=> regRdata[ISF_BIT_FIELDBUS] == $past(fieldbusEvent);
    endproperty
    a_fieldbus: assert property (p_fieldbus) else $error("fieldbus bit wrong");

    property p_mask_read;
        @(posedge clk) disable iff (!resetn)
        (regRd && regAddr == ISF_MASK_OFS) |=> regRdata == $past(mask_r);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

    property p_pend_read;
        @(posedge clk) disable iff (!resetn)
        (regRd && regAddr == ISF_PEND_OFS) |=> regRdata == {31'h00000000, $past(pendingIrq)};
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending readback wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!resetn)
        (regRd && regAddr != ISF_FLAG_OFS && regAddr != ISF_MASK_OFS && regAddr != ISF_PEND_OFS)
            |=> regRdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rd_idle;
        @(posedge clk) disable iff (!resetn)
        !regRd |=> regRdata == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outlived its cycle");

    property p_mask_wr;
        @(posedge clk) disable iff (!resetn)
        maskWr |=> mask_r == ($past(regWdata) & ISF_IMPL_MASK);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    property p_mask_keep;
        @(posedge clk) disable iff (!resetn)
        !maskWr |=> $stable(mask_r);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed");

    property p_irq_live;
        @(posedge clk) disable iff (!resetn)
        (pendingIrq && !deassertActive) |=> irqOut;
    endproperty
    a_irq_live: assert property (p_irq_live) else $error("irq not raised");

    property p_irq_idle;
        @(posedge clk) disable iff (!resetn)
        !pendingIrq |=> !irqOut;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq without source");

    sequence s_wake_armed;
        wakeDetect && mask_r[ISF_BIT_WAKE] && !maskWr;
    endsequence

    property p_wake_path;
        @(posedge clk) disable iff (!resetn)
        s_wake_armed |=> ##1 irqOut;
    endproperty
    a_wake_path: assert property (p_wake_path) else $error("wake irq late");
endmodule
`default_nettype wire

/* design/isf_pkg.sv */
// Package: register map, field positions and reset values of the interrupt status flags block
`default_nettype none
package isf_pkg;
    localparam int ISF_ADDR_W = 12;
    localparam int ISF_DATA_W = 32;
    localparam logic [11:0] ISF_FLAG_OFS = 12'h058;
    localparam logic [11:0] ISF_MASK_OFS = 12'h05C;
    localparam logic [11:0] ISF_DEAS_OFS = 12'h060;
    localparam logic [11:0] ISF_PEND_OFS = 12'h064;
    localparam int ISF_BIT_SW = 31;
    localparam int ISF_BIT_READY = 30;
    localparam int ISF_BIT_XCVR_B = 27;
    localparam int ISF_BIT_XCVR_A = 26;
    localparam int ISF_BIT_TIMER = 19;
    localparam int ISF_BIT_WAKE = 17;
    localparam int ISF_BIT_FIELDBUS = 0;
    localparam logic [31:0] ISF_IMPL_MASK = 32'hCC0A0001;
    localparam logic [31:0] ISF_W1C_MASK = 32'hC00A0000;
    localparam logic [31:0] ISF_FLAG_RST = 32'h00000000;
    localparam logic [31:0] ISF_MASK_RST = 32'h00000000;
    localparam logic [15:0] ISF_TIMER_WRAP = 16'hFFFF;
    localparam int ISF_READY_DELAY_NS = 100;
    localparam int ISF_CLK_NS = 10;
    localparam int ISF_READY_CYC = (ISF_READY_DELAY_NS + ISF_CLK_NS - 1) / ISF_CLK_NS;
endpackage
`default_nettype wire

/* design/isf_wrap_detect.sv */
// Timer wrap detector: one-cycle pulse when the count goes from zero to all ones
`default_nettype none
module isf_wrap_detect #(
    parameter int CountW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Timer count
    input wire logic [CountW-1:0] count,
    output logic wrapPulse
);
    import isf_pkg::*;

    logic [CountW-1:0] prevCount_r;
    logic seen_r;

    initial begin
        if (CountW < 2) begin
            $error("CountW must be at least 2");
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prevCount_r <= '0;
            seen_r <= 1'b0;
        end else begin
            prevCount_r <= count;
            seen_r <= 1'b1;
        end
    end

    // The first sampled value is not trusted, so a reset mid-count gives no false wrap
    assign wrapPulse = seen_r && (prevCount_r == '0) && (count == '1);
endmodule
`default_nettype wire

/* testbench/interrupt_status_flags_tb.sv */
// Testbench for the interrupt status flags block
`default_nettype none
module interrupt_status_flags_tb import isf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, regWr, regRd, xA, xB, fb, wDet, wPend, deas, pendingIrq, irqOut;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata, rv;
    logic [15:0] tmr;
    int fails = 0;
    int n_compared = 0;
    isf_host_model host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));
    interrupt_status_flags #(.TimerW(16)) DUT (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .transceiverAEvent(xA), .transceiverBEvent(xB), .fieldbusEvent(fb),
        .timerCountValue(tmr), .wakeDetect(wDet), .wakeControlPending(wPend),
        .deassertActive(deas), .pendingIrq(pendingIrq), .irqOut(irqOut));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        host.rd(a, rv);
        chk(what, exp, rv);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'h0;
        {xA, xB, fb, wDet, wPend, deas} = 6'h0;
        // Nonzero start so the first timer move is not taken for a wrap
        tmr = 16'h0005;
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        rdc("flags early", ISF_FLAG_OFS, 32'h0);
        tick(ISF_READY_CYC);
        rdc("ready set", ISF_FLAG_OFS, 32'h40000000);
        host.wr(ISF_FLAG_OFS, 32'h40000000);
        rdc("ready clr", ISF_FLAG_OFS, 32'h0);
        rdc("mask rst", ISF_MASK_OFS, ISF_MASK_RST);
        $display("reset test done");
        xA <= 1'h1;
        xB <= 1'h1;
        fb <= 1'h1;
        rdc("live src", ISF_FLAG_OFS, 32'h0C000001);
        host.wr(ISF_FLAG_OFS, 32'hFFFFFFFF);
        rdc("ro ignore", ISF_FLAG_OFS, 32'h0C000001);
        {xA, xB, fb} <= 3'h0;
        rdc("src gone", ISF_FLAG_OFS, 32'h0);
        rdc("unmapped", 12'h100, 32'h0);
        $display("source test done");
        host.wr(ISF_MASK_OFS, 32'h80000000);
        rdc("sw set", ISF_FLAG_OFS, 32'h80000000);
        chk("pending sw", 32'h1, {31'h0, pendingIrq});
        host.wr(ISF_MASK_OFS, 32'h0);
        host.wr(ISF_FLAG_OFS, 32'h80000000);
        rdc("sw clr", ISF_FLAG_OFS, 32'h0);
        chk("pending none", 32'h0, {31'h0, pendingIrq});
        $display("software test done");
        tmr <= 16'h0000;
        tick(1);
        tmr <= ISF_TIMER_WRAP;
        rdc("wrap set", ISF_FLAG_OFS, 32'h00080000);
        host.wr(ISF_FLAG_OFS, 32'h0);
        rdc("zero write", ISF_FLAG_OFS, 32'h00080000);
        host.wr(ISF_FLAG_OFS, 32'h00080000);
        rdc("wrap clr", ISF_FLAG_OFS, 32'h0);
        $display("timer test done");
        wPend <= 1'h1;
        wDet <= 1'h1;
        tick(1);
        wDet <= 1'h0;
        rdc("wake set", ISF_FLAG_OFS, 32'h00020000);
        host.wr(ISF_FLAG_OFS, 32'h00020000);
        rdc("wake held", ISF_FLAG_OFS, 32'h00020000);
        // Host clears the wake control bits before acknowledging the flag
        wPend <= 1'h0;
        host.wr(ISF_FLAG_OFS, 32'h00020000);
        rdc("wake clr", ISF_FLAG_OFS, 32'h0);
        host.wr(ISF_MASK_OFS, 32'h00020000);
        deas <= 1'h1;
        wDet <= 1'h1;
        tick(1);
        wDet <= 1'h0;
        tick(2);
        chk("wake irq", 32'h1, {31'h0, irqOut});
        host.wr(ISF_MASK_OFS, 32'h04000000);
        host.wr(ISF_FLAG_OFS, 32'h00020000);
        xA <= 1'h1;
        tick(3);
        chk("pend held", 32'h1, {31'h0, pendingIrq});
        chk("irq held", 32'h0, {31'h0, irqOut});
        rdc("pend reg", ISF_PEND_OFS, 32'h1);
        deas <= 1'h0;
        tick(3);
        chk("irq live", 32'h1, {31'h0, irqOut});
        xA <= 1'h0;
        host.wr(ISF_MASK_OFS, 32'hFFFFFFFF);
        rdc("mask bits", ISF_MASK_OFS, ISF_IMPL_MASK);
        host.wr(ISF_FLAG_OFS, 32'h80000000);
        rdc("sw kept", ISF_FLAG_OFS, 32'h80000000);
        $display("wake and output test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* testbench/isf_host_model.sv */
// Host processor model driving the register port one strobe at a time
`default_nettype none
module isf_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [11:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regAddr = 12'h0;
        regWdata = 32'h0;
        regWr = 1'h0;
        regRd = 1'h0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
        // A released bus shows the inverse, so a stale value never passes as live
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask
endmodule
`default_nettype wire
